// ==== core/pss_clk_div.sv ====
// Power-of-two clock divider producing a one-cycle tick enable
`timescale 1ns/1ps
module pss_clk_div #(
    parameter int SEL_W = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic i_step,
    input wire logic [SEL_W-1:0] i_div_sel,
    output logic o_tick
);
    localparam int CNT_W = (1 << SEL_W);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;
    logic hit;

    // Divide by 2**sel; sel of zero passes every step
    assign limit = CNT_W'((1 << i_div_sel) - 1);
    assign hit = i_run && i_step && (cnt_q >= limit);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
        end else if (!i_run || hit) begin
            cnt_q <= '0;
        end else if (i_step) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // A ratio change takes effect at once; a count already past the new limit gives a short tick
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= hit;
        end
    end

endmodule : pss_clk_div

// ==== core/pss_ctrl.sv ====
// Power saving mode controller: run modes, idle, sleep and wake-up
`timescale 1ns/1ps
// Contract
// RQ1: Reduced power entered only on software request
// RQ2: Run clock from fast, low-power or secondary
// RQ3: Peripheral bus clock scaled independently of CPU
// RQ4: Idle and sleep gate CPU, any source
// RQ5: Idle keeps source and enabled peripherals running
// RQ6: Low-power oscillator idle is lowest clocked state
// RQ7: Sleep stops CPU, source and its peripherals
// RQ8: Selected peripherals run in sleep and wake
// RQ9: Sleep wake waits oscillator dependent start-up time
// RQ10: Fail-safe clock monitor off during sleep
// RQ11: Brownout detector stays on in sleep
// RQ12: Watchdog count not cleared on sleep entry
// RQ13: Listed low-function units may run in sleep
// RQ14: Output pins keep driving during sleep
// RQ15: USB may keep primary or fast oscillator
// RQ16: Software disables modules before sleep
// RQ17: Wake restarts sources, then CPU clock cleanly
module pss_ctrl
    import pss_pkg::*;
#(
    parameter int NPER = 8,
    parameter logic [DLY_W-1:0] FAST_DLY = FAST_START_CYC,
    parameter logic [DLY_W-1:0] LOWP_DLY = LOWP_START_CYC,
    parameter logic [DLY_W-1:0] SOSC_DLY = SOSC_START_CYC,
    parameter logic [DLY_W-1:0] POSC_DLY = POSC_START_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire pss_pkg::pss_src_t i_sys_src_sel,
    input wire logic [pss_pkg::FAST_DIV_W-1:0] i_fast_post_sel,
    input wire logic [pss_pkg::PB_DIV_W-1:0] i_pb_div_sel,
    input wire logic i_wait_req,
    input wire logic i_sleep_sel,
    input wire logic i_irq_pend,
    input wire logic [pss_pkg::NKEEP-1:0] i_wake_req_async,
    input wire logic [pss_pkg::NKEEP-1:0] i_sleep_keep_en,
    input wire logic [NPER-1:0] i_periph_on,
    input wire logic i_usb_keep_posc,
    input wire logic i_usb_keep_fast,
    input wire logic i_wdt_on,
    output logic o_cpu_clk_en,
    output logic o_sys_clk_en,
    output logic o_pb_clk_en,
    output logic [NPER-1:0] o_periph_clk_en,
    output logic [pss_pkg::NSRC-1:0] o_osc_en,
    output logic [pss_pkg::NKEEP-1:0] o_keep_run,
    output logic o_clk_mon_en,
    output logic o_brownout_en,
    output logic o_wdt_run,
    output logic o_io_drive_keep,
    output logic o_in_idle,
    output logic o_in_sleep
);

    pss_state_t state_q;
    pss_state_t state_d;
    pss_src_t src_q;

    logic [NKEEP-1:0] wake_meta_q;
    logic [NKEEP-1:0] wake_sync_q;
    logic wake_hit;
    logic wake_src_kept;

    logic [DLY_W-1:0] dly_q;
    logic [DLY_W-1:0] dly_d;
    logic dly_done;

    logic sys_run;
    logic sys_run_d;
    logic fast_tick;
    logic pb_tick;
    logic fast_step;
    logic sys_tick;
    logic [NSRC-1:0] osc_en_d;
    logic [NKEEP-1:0] keep_d;

    // Start-up wait for whichever source feeds the system clock
    function automatic logic [DLY_W-1:0] src_delay(input pss_src_t s);
        logic [DLY_W-1:0] v;
        v = FAST_DLY;
        case (s)
            SRC_FAST: begin
                v = FAST_DLY;
            end
            SRC_LOWP: begin
                v = LOWP_DLY;
            end
            SRC_SOSC: begin
                v = SOSC_DLY;
            end
            SRC_POSC: begin
                v = POSC_DLY;
            end
            default: begin
                v = FAST_DLY;
            end
        endcase
        return v;
    endfunction : src_delay

    // Whether USB holds the given source alive through sleep
    function automatic logic usb_holds(
        input pss_src_t s,
        input logic keep_posc,
        input logic keep_fast
    );
        return ((s == SRC_POSC) && keep_posc) || ((s == SRC_FAST) && keep_fast);
    endfunction : usb_holds

    // Wake requests arrive from pins and slow-clock units
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            wake_meta_q <= '0;
            wake_sync_q <= '0;
        end else begin
            wake_meta_q <= i_wake_req_async;
            wake_sync_q <= wake_meta_q;
        end
    end

    // Only functions left alive in sleep may wake it
    assign wake_hit = |(wake_sync_q & i_sleep_keep_en); // RQ8
    assign wake_src_kept = usb_holds(src_q, i_usb_keep_posc, i_usb_keep_fast);
    assign dly_done = (dly_q == '0);

    always_comb begin
        state_d = state_q;
        dly_d = dly_q;
        case (state_q)
            ST_RUN: begin
                // Only the software wait request leaves run
                if (i_wait_req) begin // RQ1
                    if (i_sleep_sel) begin
                        state_d = ST_SLEEP; // RQ4
                    end else begin
                        state_d = ST_IDLE; // RQ4
                    end
                end
            end
            ST_IDLE: begin
                // Source never stopped, so no start-up wait
                if (i_irq_pend || wake_hit) begin
                    state_d = ST_RUN; // RQ17
                end
            end
            ST_SLEEP: begin
                if (i_irq_pend || wake_hit) begin
                    state_d = ST_WAKE;
                    if (wake_src_kept) begin
                        dly_d = '0;
                    end else begin
                        dly_d = src_delay(src_q); // RQ9
                    end
                end
            end
            ST_WAKE: begin
                if (dly_done) begin
                    state_d = ST_RUN; // RQ17
                end else begin
                    dly_d = dly_q - DLY_W'(1);
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= ST_RUN;
            dly_q <= '0;
        end else begin
            state_q <= state_d;
            dly_q <= dly_d;
        end
    end

    // Source choice is frozen outside run so a wake uses the
    // oscillator that was stopped, not a half-changed selection
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            src_q <= SRC_FAST;
        end else if (state_q == ST_RUN) begin
            src_q <= i_sys_src_sel; // RQ2
        end
    end

    // System clock runs in every state but sleep and its wait
    assign sys_run = (state_q == ST_RUN) || (state_q == ST_IDLE); // RQ5 RQ7
    // Gates that leave with the state flags use the next state
    assign sys_run_d = (state_d == ST_RUN) || (state_d == ST_IDLE); // RQ7
    assign fast_step = sys_run && (src_q == SRC_FAST);

    pss_clk_div #(
        .SEL_W(FAST_DIV_W)
    ) u_fast_post (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_run(fast_step),
        .i_step(1'b1),
        .i_div_sel(i_fast_post_sel),
        .o_tick(fast_tick)
    );

    // Fast oscillator may be postscaled, the others run straight
    assign sys_tick = (src_q == SRC_FAST) ? fast_tick : sys_run; // RQ2

    // Bus scaler counts system ticks, not CPU ticks
    pss_clk_div #(
        .SEL_W(PB_DIV_W)
    ) u_pb_div (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_run(sys_run),
        .i_step(sys_tick),
        .i_div_sel(i_pb_div_sel),
        .o_tick(pb_tick)
    ); // RQ3

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_sys_clk_en <= 1'b0;
        end else begin
            o_sys_clk_en <= sys_tick && sys_run_d; // RQ7
        end
    end

    // Registered gate keeps the CPU enable free of glitches
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= (state_d == ST_RUN) && sys_tick; // RQ4 RQ17
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_pb_clk_en <= 1'b0;
        end else begin
            o_pb_clk_en <= pb_tick; // RQ3
        end
    end

    // Disabled modules get no clock in any state
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_periph_clk_en <= '0;
        end else if (pb_tick && sys_run_d) begin
            o_periph_clk_en <= i_periph_on; // RQ5 RQ16
        end else begin
            o_periph_clk_en <= '0; // RQ7
        end
    end

    // Sleep keeps only the slow-clocked functions software left on
    always_comb begin
        if (state_q == ST_SLEEP || state_q == ST_WAKE) begin
            keep_d = i_sleep_keep_en; // RQ13 RQ16
            keep_d[KEEP_WDT] = i_wdt_on;
        end else begin
            keep_d = '1;
            keep_d[KEEP_WDT] = i_wdt_on;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_keep_run <= '0;
        end else begin
            o_keep_run <= keep_d; // RQ8 RQ13
        end
    end

    // Oscillator enables: selected source stops in sleep unless
    // USB holds it; slow oscillators stay for alive functions
    always_comb begin
        osc_en_d = '0;
        if (sys_run) begin
            osc_en_d[src_q] = 1'b1; // RQ5 RQ6
        end else if (state_q == ST_WAKE) begin
            osc_en_d[src_q] = 1'b1; // RQ17
        end
        if (i_usb_keep_posc) begin
            osc_en_d[SRC_POSC] = 1'b1; // RQ15
        end
        if (i_usb_keep_fast) begin
            osc_en_d[SRC_FAST] = 1'b1; // RQ15
        end
        if (i_wdt_on || keep_d[KEEP_TMR1] || keep_d[KEEP_ICAP]) begin
            osc_en_d[SRC_LOWP] = 1'b1; // RQ13
        end
        if (keep_d[KEEP_CAL]) begin
            osc_en_d[SRC_SOSC] = 1'b1; // RQ13
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_osc_en <= '0;
        end else begin
            o_osc_en <= osc_en_d; // RQ7
        end
    end

    // Monitor would flag the stopped source as failed
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_clk_mon_en <= 1'b0;
        end else begin
            o_clk_mon_en <= sys_run_d; // RQ10
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_brownout_en <= 1'b0;
        end else begin
            o_brownout_en <= 1'b1; // RQ11
        end
    end

    // Sleep entry passes no clear to the watchdog; only its own
    // enable steers it, so software must service it first
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_wdt_run <= 1'b0;
        end else begin
            o_wdt_run <= i_wdt_on; // RQ12
        end
    end

    // Pad drivers are never released by a power state
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_io_drive_keep <= 1'b0;
        end else begin
            o_io_drive_keep <= 1'b1; // RQ14
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_in_idle <= 1'b0;
            o_in_sleep <= 1'b0;
        end else begin
            o_in_idle <= (state_d == ST_IDLE);
            o_in_sleep <= (state_d == ST_SLEEP) || (state_d == ST_WAKE);
        end
    end

endmodule : pss_ctrl

// ==== shared/pss_pkg.sv ====
// Shared constants and types for the power saving mode controller
package pss_pkg;

    // Core clock rate used to turn times into cycles
    localparam int CLK_MHZ = 250;

    // Clock source selection codes
    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_LOWP = 2'h1,
        SRC_SOSC = 2'h2,
        SRC_POSC = 2'h3
    } pss_src_t;
    localparam int NSRC = 4;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_IDLE = 4'h2,
        ST_SLEEP = 4'h4,
        ST_WAKE = 4'h8
    } pss_state_t;

    // Functions that may stay alive in sleep
    localparam int KEEP_PINCHG = 0;
    localparam int KEEP_WDT = 1;
    localparam int KEEP_ADC = 2;
    localparam int KEEP_UART = 3;
    localparam int KEEP_CAL = 4;
    localparam int KEEP_TMR1 = 5;
    localparam int KEEP_ICAP = 6;
    localparam int NKEEP = 7;

    // Wake-up start-up times per oscillator, in ns
    localparam int FAST_START_NS = 2000;
    localparam int LOWP_START_NS = 4000;
    localparam int SOSC_START_NS = 8000;
    localparam int POSC_START_NS = 10000;

    localparam int DLY_W = 12;
    localparam int FAST_DIV_W = 3;
    localparam int PB_DIV_W = 2;

    // Least time rounds up, never below one cycle
    function automatic logic [DLY_W-1:0] pss_ns2cyc(input int ns);
        int cyc;
        cyc = (ns * CLK_MHZ + 999) / 1000;
        if (cyc < 1) begin
            cyc = 1;
        end
        return DLY_W'(cyc);
    endfunction : pss_ns2cyc

    localparam logic [DLY_W-1:0] FAST_START_CYC = pss_ns2cyc(FAST_START_NS);
    localparam logic [DLY_W-1:0] LOWP_START_CYC = pss_ns2cyc(LOWP_START_NS);
    localparam logic [DLY_W-1:0] SOSC_START_CYC = pss_ns2cyc(SOSC_START_NS);
    localparam logic [DLY_W-1:0] POSC_START_CYC = pss_ns2cyc(POSC_START_NS);

endpackage : pss_pkg

// ==== tb/pss_ctrl_checker.sv ====
// Port-level checks for the power saving controller
`timescale 1ns/1ps
module pss_ctrl_checker
    import pss_pkg::*;
#(
    parameter int NPER = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_wait_req,
    input wire logic i_irq_pend,
    input wire logic [NPER-1:0] i_periph_on,
    input wire logic i_wdt_on,
    input wire logic o_cpu_clk_en,
    input wire logic o_sys_clk_en,
    input wire logic [NPER-1:0] o_periph_clk_en,
    input wire logic o_clk_mon_en,
    input wire logic o_brownout_en,
    input wire logic o_wdt_run,
    input wire logic o_io_drive_keep,
    input wire logic o_in_idle,
    input wire logic o_in_sleep
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    a_idle_cpu_gate: assert property (o_in_idle |-> !o_cpu_clk_en)
        else $error("cpu clock runs in idle");
    a_sleep_stops_all: assert property (o_in_sleep |->
        !o_cpu_clk_en && !o_sys_clk_en && o_periph_clk_en == '0)
        else $error("clock runs in sleep");
    a_mon_sleep_off: assert property (o_in_sleep |-> !o_clk_mon_en)
        else $error("clock monitor on in sleep");
    a_brownout_stays_on: assert property ($past(i_rst_b) |-> o_brownout_en)
        else $error("brownout detector off");
    a_pins_keep_drive: assert property ($past(i_rst_b) |-> o_io_drive_keep)
        else $error("pins released");
    a_sw_entry_only: assert property ($rose(o_in_idle) || $rose(o_in_sleep) |->
        $past(i_wait_req))
        else $error("low power entered without request");
    a_idle_wake_fast: assert property (o_in_idle && i_irq_pend |-> ##[1:2] !o_in_idle)
        else $error("idle wake late");
    a_sleep_wake_bound: assert property (o_in_sleep && i_irq_pend |->
        ##[1:16] !o_in_sleep)
        else $error("sleep wake late");
    a_wdt_count_kept: assert property ($past(i_rst_b) |->
        o_wdt_run == $past(i_wdt_on))
        else $error("watchdog run wrong");
    a_periph_off_gate: assert property ($past(i_rst_b) |->
        (o_periph_clk_en & ~$past(i_periph_on)) == '0)
        else $error("disabled module clocked");
    c_idle: cover property ($rose(o_in_idle));
    c_sleep: cover property ($rose(o_in_sleep));
    c_sleep_wake: cover property ($fell(o_in_sleep));
endmodule : pss_ctrl_checker

bind pss_ctrl pss_ctrl_checker #(.NPER(NPER)) u_pss_ctrl_checker (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_wait_req(i_wait_req),
    .i_irq_pend(i_irq_pend),
    .i_periph_on(i_periph_on),
    .i_wdt_on(i_wdt_on),
    .o_cpu_clk_en(o_cpu_clk_en),
    .o_sys_clk_en(o_sys_clk_en),
    .o_periph_clk_en(o_periph_clk_en),
    .o_clk_mon_en(o_clk_mon_en),
    .o_brownout_en(o_brownout_en),
    .o_wdt_run(o_wdt_run),
    .o_io_drive_keep(o_io_drive_keep),
    .o_in_idle(o_in_idle),
    .o_in_sleep(o_in_sleep)
);

// ==== tb/tb.sv ====
// Self-checking bench for the power saving controller
`timescale 1ns/1ps
module tb;
    import pss_pkg::*;
    localparam int NP = 8;
    // Short start-up counts keep the run brief
    localparam int DLY [4] = '{4, 5, 6, 7};
    logic clk, rst_b, wait_req, slp_sel, irq, usb_p, usb_f, wdt_on, h;
    pss_src_t src;
    logic [FAST_DIV_W-1:0] fast_sel;
    logic [PB_DIV_W-1:0] pb_sel;
    logic [NKEEP-1:0] wake_a, keep_en, keep_run;
    logic [NP-1:0] per_on, per_en;
    logic [NSRC-1:0] osc_en;
    logic cpu_en, sys_en, pb_en, clk_mon, brown, wdt_run, io_keep, in_idle, in_sleep;
    logic [1:0] prev;
    logic [1:0] exp_q [$];
    int error_cnt, compares, n, m, s;

    pss_ctrl #(.NPER(NP), .FAST_DLY(DLY_W'(DLY[0])), .LOWP_DLY(DLY_W'(DLY[1])),
        .SOSC_DLY(DLY_W'(DLY[2])), .POSC_DLY(DLY_W'(DLY[3]))) u_pss_ctrl (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_sys_src_sel(src),
        .i_fast_post_sel(fast_sel), .i_pb_div_sel(pb_sel), .i_wait_req(wait_req),
        .i_sleep_sel(slp_sel), .i_irq_pend(irq), .i_wake_req_async(wake_a),
        .i_sleep_keep_en(keep_en), .i_periph_on(per_on), .i_usb_keep_posc(usb_p),
        .i_usb_keep_fast(usb_f), .i_wdt_on(wdt_on), .o_cpu_clk_en(cpu_en),
        .o_sys_clk_en(sys_en), .o_pb_clk_en(pb_en), .o_periph_clk_en(per_en),
        .o_osc_en(osc_en), .o_keep_run(keep_run), .o_clk_mon_en(clk_mon),
        .o_brownout_en(brown),
        .o_wdt_run(wdt_run), .o_io_drive_keep(io_keep), .o_in_idle(in_idle),
        .o_in_sleep(in_sleep));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    // Flag pair 2'b11 marks a request that must be ignored
    task automatic enter(input logic sl, input logic [1:0] e);
        @(posedge clk);
        slp_sel <= sl;
        wait_req <= 1'b1;
        if (e != 2'b11) exp_q.push_back(e);
        @(posedge clk);
        wait_req <= 1'b0;
        cyc(3);
    endtask : enter

    task automatic wake(input logic [NKEEP-1:0] w);
        exp_q.push_back(2'b00);
        @(posedge clk);
        if (w == '0) irq <= 1'b1;
        else wake_a <= w;
        n = 0;
        while ((in_idle || in_sleep) && n < 40) begin
            @(posedge clk);
            n++;
        end
        irq <= 1'b0;
        wake_a <= '0;
    endtask : wake

    task automatic tally(input logic pb, output int c);
        cyc(8);
        c = 0;
        repeat (64) begin
            cyc(1);
            if ((pb ? pb_en : sys_en) === 1'b1) c++;
        end
    endtask : tally

    // Flag changes are paired with the oldest expectation
    always @(posedge clk) begin
        if (rst_b && {in_idle, in_sleep} !== prev) begin
            if (exp_q.size() == 0) chk({in_idle, in_sleep}, prev, "unrequested state change");
            else chk({in_idle, in_sleep}, exp_q.pop_front(), "state flags");
        end
        prev <= {in_idle, in_sleep};
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #200000;
        error_cnt++;
        close_out();
    end

    initial begin
        {rst_b, wait_req, slp_sel, irq, usb_p, usb_f, wdt_on, prev} = '0;
        {fast_sel, pb_sel, wake_a, keep_en, per_on} = '0;
        src = SRC_FAST;
        error_cnt = 0;
        compares = 0;
        void'($urandom(32'h465a));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        chk(brown, 1, "brownout off");
        chk(io_keep, 1, "pins released");
        chk(clk_mon, 1, "monitor off in run");
        repeat (40) begin
            @(posedge clk);
            irq <= 1'($urandom);
            slp_sel <= 1'($urandom);
        end
        @(posedge clk);
        irq <= 1'b0;
        $display("test reset_and_no_entry done");
        for (s = 0; s < NSRC; s++) begin
            @(posedge clk);
            src <= pss_src_t'(s);
            per_on <= NP'($urandom);
            enter(1'b0, 2'b10);
            chk(osc_en[s], 1, "idle source stopped");
            chk(clk_mon, 1, "monitor off in idle");
            n = 0;
            m = 0;
            repeat (16) begin
                cyc(1);
                if (cpu_en !== 1'b0 || (per_en & ~per_on) !== '0) n++;
                if (pb_en === 1'b1) m++;
            end
            chk(n, 0, "idle gating");
            chk(m > 0, 1, "bus clock stopped in idle");
            enter(1'b1, 2'b11);
            wake('0);
            chk(n <= 3, 1, "idle wake slow");
        end
        $display("test idle done");
        for (int k = 0; k < 2 * NSRC; k++) begin
            s = k % NSRC;
            h = 1'(k / NSRC);
            @(posedge clk);
            src <= pss_src_t'(s);
            {usb_p, usb_f} <= {h, h};
            keep_en <= NKEEP'($urandom);
            wdt_on <= 1'($urandom);
            enter(1'b1, 2'b01);
            chk({cpu_en, sys_en, per_en}, '0, "clocks run in sleep");
            chk(clk_mon, 0, "monitor on in sleep");
            chk(brown, 1, "brownout off in sleep");
            chk(wdt_run, wdt_on, "watchdog stopped");
            chk(keep_run, (keep_en & ~7'h02) | {5'h00, wdt_on, 1'b0}, "kept units");
            if (s == 0 || s == 3) chk(osc_en[s], h, "usb source hold");
            wake('0);
            chk(n <= DLY[s] + 5 && (h || n >= DLY[s]), 1, "sleep wake time");
            cyc(1);
            chk(osc_en[s], 1, "source not restarted");
        end
        $display("test sleep done");
        @(posedge clk);
        {src, usb_p, usb_f} <= {SRC_FAST, 2'b00};
        keep_en <= 7'h01;
        enter(1'b1, 2'b01);
        @(posedge clk);
        wake_a <= 7'h08;
        cyc(20);
        wake(7'h01);
        chk(n <= DLY[0] + 7 && n >= DLY[0], 1, "async wake time");
        $display("test async_wake done");
        @(posedge clk);
        src <= SRC_POSC;
        for (int d = 0; d < 4; d++) begin
            @(posedge clk);
            pb_sel <= PB_DIV_W'(d);
            tally(1'b1, n);
            chk(n, 64 >> d, "bus clock ratio");
            chk(cpu_en, 1, "cpu clock stopped in run");
        end
        @(posedge clk);
        src <= SRC_FAST;
        pb_sel <= '0;
        for (int d = 0; d < 4; d++) begin
            @(posedge clk);
            fast_sel <= FAST_DIV_W'(d);
            tally(1'b0, n);
            chk(n, 64 >> d, "fast postscale ratio");
        end
        $display("test dividers done");
        close_out();
    end
endmodule : tb
